// ### hdl/aoq_device.sv
// Overview of operation
// [RL1] identify reports 4-bit queue depth field
// [RL2] abort commands whose tag exceeds depth field
// [RL3] registers 16 bits, other upper bytes ignored
// [RL4] command upper byte: overlap flag and tag
// [RL5] status upper bit 15 is command complete
// [RL6] service request shows tag in status bits
// [RL7] queued commands simple, no tag priority
// [RL8] power up in legacy mode until told
// [RL9] set features code selects overlap selection kind
// [RL10] features off, hard reset, power-down abort queue
// [RL11] software reset aborts queue, keeps mode
// [RL12] bit-select mode entry shown by busy set
// [RL13] chip-select mode decodes blocks by both lines
// [RL14] intermediate: device 1 answers both-asserted only
// [RL15] host enter sequence, device 1 first, wait
// [RL16] host leave sequence, device 0 first, wait
// [RL17] host avoids control block when intermediate
// [RL18] data command: busy, block writes, save, release
// [RL19] unselected overlapped device ignores bus accesses
// [RL20] chip-select mode: separate interrupt line per device
// [RL21] tag-indexed table of saved command entries
`timescale 1ns/1ps
module aoq_device (
  input wire logic i_sys_clk, // device clock, 200 MHz
  input wire logic i_arst_n, // hardware reset, active low
  aoq_bus_if.device bus, // shared register bus
  input wire logic i_dev_id, // strap: 0 device 0, 1 device 1
  input wire logic i_power_down, // power-down event, level
  input wire logic i_svc_req, // backend requests service, pulse
  input wire logic i_svc_done, // backend finished tag, pulse
  input wire logic [3:0] i_svc_tag, // tag for request or done
  output logic [3:0] o_id_queue_depth, // identify queue depth field
  output aoq_pkg::aoq_mode_e o_mode, // current selection mode
  output logic [15:0] o_queue_valid, // occupied tags
  output aoq_pkg::aoq_entry_s o_svc_entry // saved entry at i_svc_tag
);
  import aoq_pkg::*;

  aoq_dev_st_e st;
  aoq_mode_e mode;
  logic [7:0] cnt;
  logic bsy;
  logic dev_id;
  logic id_seen;
  logic dev_sel;
  logic [7:0] feat;
  logic [7:0] count;
  logic [7:0] sector;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic [3:0] head;
  logic [7:0] err_reg;
  logic cc;
  logic err;
  logic irq;
  logic [3:0] svc_tag;
  logic [7:0] cur_cmd;
  logic [3:0] cur_tag;
  logic hit_cmd;
  logic hit_ctl;
  logic selected;
  logic cmd_wr;
  logic srst;
  logic flush;
  logic start;
  logic bad_tag;
  logic feat_ok;
  logic save_done;
  logic exec_done;
  logic [15:0] status_word;
  aoq_entry_s save_entry;

  assign o_id_queue_depth = QUEUE_DEPTH_FIELD; // see [RL1]
  assign o_mode = mode;

  // strap is taken once, after reset release
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dev_id <= 1'b0;
      id_seen <= 1'b0;
    end
    else if (!id_seen)
    begin
      dev_id <= i_dev_id;
      id_seen <= 1'b1;
    end
  end

  always_comb
  begin
    if (mode == chipselect_overlap_mode)
    begin
      // own block pair chosen by cs1 level  see [RL13] see [RL14]
      hit_cmd = !bus.cs0_n && (bus.cs1_n == !dev_id);
      hit_ctl = bus.cs0_n && (bus.cs1_n == !dev_id);
      selected = 1'b1;
    end
    else
    begin
      hit_cmd = !bus.cs0_n && bus.cs1_n;
      hit_ctl = bus.cs0_n && !bus.cs1_n;
      selected = (dev_sel == dev_id); // see [RL12]
    end
  end

  // the device/head write must reach both devices so each learns the selection
  assign cmd_wr = bus.wr && hit_cmd && !bsy; // see [RL18]
  assign srst = bus.wr && hit_ctl && bus.da == RA_DEVCTL && bus.wdata[DC_SRST_BIT];
  assign start = cmd_wr && bus.da == RA_CMD && selected && st == ST_IDLE;
  assign bad_tag = bus.wdata[CW_TAG_LSB +: 4] > QUEUE_DEPTH_FIELD
    || QUEUE_DEPTH_FIELD == 4'h0; // see [RL2]
  assign feat_ok = feat == FEAT_OVL_BITSEL || feat == FEAT_OVL_CHIPSEL
    || feat == FEAT_OVL_OFF;
  assign save_done = st == ST_SAVE && cnt == 8'h00;
  assign exec_done = st == ST_EXEC && cnt == 8'h00;
  // aborting the queue on any of these  see [RL10] see [RL11]
  assign flush = srst || i_power_down
    || (start && bus.wdata[7:0] == OP_SET_FEATURES && feat == FEAT_OVL_OFF);

  // power-up and hard reset land in legacy  see [RL8]
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      mode <= legacy_mode;
    else if (i_power_down)
      mode <= legacy_mode; // see [RL10]
    else if (start && bus.wdata[7:0] == OP_SET_FEATURES)
    begin
      // features code picks bit or chip selection  see [RL9]
      if (feat == FEAT_OVL_BITSEL)
        mode <= bitselect_overlap_mode;
      else if (feat == FEAT_OVL_CHIPSEL)
        mode <= chipselect_overlap_mode;
      else if (feat == FEAT_OVL_OFF)
        mode <= legacy_mode;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st <= ST_IDLE;
      cnt <= 8'h00;
      bsy <= 1'b0;
      cur_cmd <= 8'h00;
      cur_tag <= 4'h0;
    end
    else if (srst || i_power_down)
    begin
      st <= ST_IDLE;
      bsy <= 1'b0;
    end
    else
    begin
      case (st)
        ST_IDLE:
          if (start)
          begin
            cur_cmd <= bus.wdata[7:0];
            cur_tag <= bus.wdata[CW_TAG_LSB +: 4]; // see [RL4]
            if (bus.wdata[7:0] == OP_SET_FEATURES)
            begin
              // busy high in the new mode marks entry done  see [RL12]
              st <= ST_EXEC;
              cnt <= 8'(FEAT_BUSY_CYC - 1);
              bsy <= 1'b1;
            end
            else if (bus.wdata[CW_OVL_BIT] && mode != legacy_mode)
            begin
              if (!bad_tag)
              begin
                st <= ST_SAVE;
                cnt <= 8'(SAVE_CYC - 1);
                bsy <= 1'b1; // see [RL18]
              end
            end
            else
            begin
              st <= ST_EXEC;
              cnt <= 8'(CMD_BUSY_CYC - 1);
              bsy <= 1'b1;
            end
          end
        ST_SAVE:
          if (cnt == 8'h00)
          begin
            st <= ST_IDLE;
            bsy <= 1'b0; // see [RL18]
          end
          else
            cnt <= cnt - 8'h01;
        ST_EXEC:
          if (cnt == 8'h00)
          begin
            st <= ST_IDLE;
            bsy <= 1'b0;
          end
          else
            cnt <= cnt - 8'h01;
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  // upper bytes of these registers are dropped  see [RL3]
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dev_sel <= 1'b0;
      feat <= 8'h00;
      count <= 8'h00;
      sector <= 8'h00;
      cyl_lo <= 8'h00;
      cyl_hi <= 8'h00;
      head <= 4'h0;
    end
    else if (cmd_wr && (selected || mode == legacy_mode || bus.da == RA_DEVHEAD))
    begin
      // bit-select unselected device only takes device/head writes (selection and head)  see [RL19]
      case (bus.da)
        RA_FEAT: feat <= bus.wdata[7:0];
        RA_COUNT: count <= bus.wdata[7:0];
        RA_SECTOR: sector <= bus.wdata[7:0];
        RA_CYL_LO: cyl_lo <= bus.wdata[7:0];
        RA_CYL_HI: cyl_hi <= bus.wdata[7:0];
        RA_DEVHEAD:
        begin
          if (mode != chipselect_overlap_mode)
            dev_sel <= bus.wdata[DH_DEV_BIT];
          head <= bus.wdata[3:0];
        end
        default: ;
      endcase
    end
  end

  assign save_entry = '{cmd: cur_cmd, count: count, sector: sector, cyl_lo: cyl_lo,
    cyl_hi: cyl_hi, head: head};

  aoq_tag_table u_table (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_wr(save_done && !srst && !i_power_down),
    .i_wr_tag(cur_tag),
    .i_wr_entry(save_entry),
    .i_clr(i_svc_done),
    .i_clr_tag(i_svc_tag),
    .i_flush(flush),
    .i_rd_tag(i_svc_tag),
    .o_valid(o_queue_valid),
    .o_entry(o_svc_entry)
  );

  // completion, error and service flags; event set wins over a read clear
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cc <= 1'b0;
      err <= 1'b0;
      err_reg <= 8'h00;
      irq <= 1'b0;
      svc_tag <= 4'h0;
    end
    else
    begin
      if (bus.rd && hit_cmd && bus.da == RA_CMD && selected)
        irq <= 1'b0;
      if (srst)
      begin
        cc <= 1'b0;
        err <= 1'b0;
        err_reg <= 8'h00;
      end
      else if (start)
      begin
        cc <= 1'b0;
        err <= 1'b0;
        err_reg <= 8'h00;
        if ((bus.wdata[7:0] == OP_SET_FEATURES && !feat_ok)
          || (bus.wdata[CW_OVL_BIT] && mode != legacy_mode && bad_tag))
        begin
          // flagged aborted at once; bad tag has no busy phase, bad features code still runs the busy phase  see [RL2]
          cc <= 1'b1;
          err <= 1'b1;
          err_reg <= ERR_ABORT;
          irq <= 1'b1;
        end
      end
      else if (exec_done)
      begin
        cc <= 1'b1; // see [RL5]
        irq <= 1'b1;
      end
      else if (i_svc_req)
        cc <= 1'b0;
      else if (i_svc_done)
        cc <= 1'b1; // see [RL5]
      // service tag and irq kept, cc update dropped, when a command start, finish or reset lands in the same cycle
      if (i_svc_req || i_svc_done)
      begin
        svc_tag <= i_svc_tag; // see [RL6]
        irq <= 1'b1;
      end
    end
  end

  // same upper byte for primary and alternate view  see [RL5] see [RL6]
  assign status_word = {cc, 3'h0, svc_tag, bsy, 1'b1, 5'h00, err};

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bus.rdata <= 16'h0000;
      bus.rdata_oe <= 1'b0;
    end
    else
    begin
      bus.rdata_oe <= bus.rd && selected && (hit_cmd || hit_ctl); // see [RL19]
      if (bus.rd && hit_ctl && bus.da == RA_DEVCTL)
        bus.rdata <= status_word;
      else if (bus.rd && hit_cmd)
      begin
        if (bus.da == RA_CMD)
          bus.rdata <= status_word;
        else if (bus.da == RA_FEAT)
          bus.rdata <= {8'h00, err_reg};
        else if (bus.da == RA_COUNT)
          bus.rdata <= {8'h00, count};
        else if (bus.da == RA_SECTOR)
          bus.rdata <= {8'h00, sector};
        else if (bus.da == RA_CYL_LO)
          bus.rdata <= {8'h00, cyl_lo};
        else if (bus.da == RA_CYL_HI)
          bus.rdata <= {8'h00, cyl_hi};
        else if (bus.da == RA_DEVHEAD)
          bus.rdata <= {8'h00, 3'h5, dev_sel, head};
        else
          bus.rdata <= 16'h0000;
      end
    end
  end

  // chip-select mode: fixed line per device, any selection  see [RL20]
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bus.intrq <= 1'b0;
      bus.second_device_interrupt <= 1'b0;
    end
    else
    begin
      if (mode == chipselect_overlap_mode)
        bus.intrq <= irq && !dev_id;
      else
        bus.intrq <= irq && selected;
      bus.second_device_interrupt <= irq && dev_id && mode == chipselect_overlap_mode;
    end
  end
endmodule

// ### include/aoq_pkg.sv
package aoq_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ = 200;
  localparam int SAVE_NS = 20;
  localparam int SAVE_CYC = (SAVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_BUSY_NS = 100;
  localparam int CMD_BUSY_CYC = (CMD_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FEAT_BUSY_NS = 200;
  localparam int FEAT_BUSY_CYC = (FEAT_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_WAIT_US = 2000;
  localparam int MODE_WAIT_CYC = MODE_WAIT_US * CLK_MHZ;
  // register addresses on the device bus
  localparam logic [2:0] RA_DATA = 3'h0;
  localparam logic [2:0] RA_FEAT = 3'h1;
  localparam logic [2:0] RA_COUNT = 3'h2;
  localparam logic [2:0] RA_SECTOR = 3'h3;
  localparam logic [2:0] RA_CYL_LO = 3'h4;
  localparam logic [2:0] RA_CYL_HI = 3'h5;
  localparam logic [2:0] RA_DEVHEAD = 3'h6;
  localparam logic [2:0] RA_CMD = 3'h7;
  localparam logic [2:0] RA_DEVCTL = 3'h6;
  // field positions
  localparam int CW_OVL_BIT = 15;
  localparam int CW_TAG_LSB = 8;
  localparam int DH_DEV_BIT = 4;
  localparam int DC_SRST_BIT = 2;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  // command and feature codes
  localparam logic [7:0] OP_SET_FEATURES = 8'hEF;
  localparam logic [7:0] FEAT_OVL_BITSEL = 8'h60;
  localparam logic [7:0] FEAT_OVL_CHIPSEL = 8'h61;
  localparam logic [7:0] FEAT_OVL_OFF = 8'hE0;
  localparam logic [3:0] QUEUE_DEPTH_FIELD = 4'hF;
  localparam int NUM_TAGS = 16;
  // host command port
  localparam logic [1:0] HR_WDATA = 2'h0;
  localparam logic [1:0] HR_ACCESS = 2'h1;
  localparam logic [1:0] HR_RESULT = 2'h2;
  localparam logic [1:0] HR_SEQ = 2'h3;
  localparam int HA_CS0_BIT = 3;
  localparam int HA_CS1_BIT = 4;
  localparam int HA_READ_BIT = 5;
  localparam int HR_BUSY_BIT = 16;
  localparam logic [4:0] SEQ_ENTER_BASE = 5'h00;
  localparam logic [4:0] SEQ_LEAVE_BASE = 5'h09;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [3:0] head;
  } aoq_entry_s;

  typedef enum logic [2:0] {
    legacy_mode = 3'b001,
    bitselect_overlap_mode = 3'b010,
    chipselect_overlap_mode = 3'b100
  } aoq_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_EXEC = 3'b100
  } aoq_dev_st_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RUN = 3'b010,
    HS_WAIT = 3'b100
  } aoq_host_st_e;
endpackage

// ### include/aoq_bus_if.sv
`timescale 1ns/1ps
interface aoq_bus_if;
  logic cs0_n;
  logic cs1_n;
  logic [2:0] da;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rdata_oe;
  logic intrq;
  logic second_device_interrupt;

  modport host (
    output cs0_n, cs1_n, da, wr, rd, wdata,
    input rdata, rdata_oe, intrq, second_device_interrupt
  );
  modport device (
    input cs0_n, cs1_n, da, wr, rd, wdata,
    output rdata, rdata_oe, intrq, second_device_interrupt
  );
endinterface

// ### hdl/aoq_tag_table.sv
`timescale 1ns/1ps
module aoq_tag_table (
  input wire logic i_sys_clk, // device clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_wr, // store entry
  input wire logic [3:0] i_wr_tag, // tag of stored entry
  input wire aoq_pkg::aoq_entry_s i_wr_entry, // saved parameters
  input wire logic i_clr, // retire one tag
  input wire logic [3:0] i_clr_tag, // tag retired
  input wire logic i_flush, // abort whole queue
  input wire logic [3:0] i_rd_tag, // lookup index
  output logic [15:0] o_valid, // occupied tags
  output aoq_pkg::aoq_entry_s o_entry // entry at lookup index
);
  import aoq_pkg::*;

  aoq_entry_s entry [NUM_TAGS];

  // plain tag-indexed slots, no ordering between them  see [RL7]
  for (genvar g = 0; g < NUM_TAGS; g++)
  begin : g_slot
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        o_valid[g] <= 1'b0;
        entry[g] <= '0;
      end
      else if (i_wr && i_wr_tag == 4'(g))
      begin
        o_valid[g] <= 1'b1; // see [RL21]
        entry[g] <= i_wr_entry;
      end
      else if (i_flush || (i_clr && i_clr_tag == 4'(g)))
      begin
        o_valid[g] <= 1'b0;
      end
    end
  end

  assign o_entry = entry[i_rd_tag];
endmodule

// ### hdl/aoq_host.sv
`timescale 1ns/1ps
module aoq_host #(
  parameter int MODE_WAIT_CYCLES = aoq_pkg::MODE_WAIT_CYC // 2 ms settle wait
) (
  input wire logic i_sys_clk, // host clock, 200 MHz
  input wire logic i_arst_n, // async reset, active low
  aoq_bus_if.host bus, // shared register bus
  input wire logic [1:0] i_addr, // command port address
  input wire logic [31:0] i_wdata, // command port write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata // read data, cycle after i_rd
);
  import aoq_pkg::*;

  aoq_host_st_e st;
  logic [15:0] wreg;
  logic [15:0] result;
  logic [4:0] pc;
  logic [18:0] timer;
  logic [22:0] step;
  logic engine_busy;

  // step: kind(0 write,1 read,2 wait,3 end), cs0 asserted, cs1 asserted, addr, data
  function automatic logic [22:0] seq_step(input logic [4:0] idx);
    logic [22:0] s;
    s = {2'h3, 21'h000000};
    case (idx)
      // enter: device 1 first, then device 0  see [RL15]
      5'h00: s = {2'h0, 2'b10, RA_DEVHEAD, 16'h0010};
      5'h01: s = {2'h0, 2'b10, RA_FEAT, 8'h00, FEAT_OVL_CHIPSEL};
      5'h02: s = {2'h0, 2'b10, RA_CMD, 8'h00, OP_SET_FEATURES};
      5'h03: s = {2'h2, 21'h000000};
      5'h04: s = {2'h1, 2'b11, RA_CMD, 16'h0000};
      5'h05: s = {2'h0, 2'b10, RA_DEVHEAD, 16'h0000};
      5'h06: s = {2'h0, 2'b10, RA_FEAT, 8'h00, FEAT_OVL_CHIPSEL};
      5'h07: s = {2'h0, 2'b10, RA_CMD, 8'h00, OP_SET_FEATURES};
      // leave: device 0 first, then device 1  see [RL16]
      5'h09: s = {2'h0, 2'b10, RA_FEAT, 8'h00, FEAT_OVL_OFF};
      5'h0A: s = {2'h0, 2'b10, RA_CMD, 8'h00, OP_SET_FEATURES};
      5'h0B: s = {2'h1, 2'b10, RA_CMD, 16'h0000};
      5'h0C: s = {2'h0, 2'b11, RA_FEAT, 8'h00, FEAT_OVL_OFF};
      5'h0D: s = {2'h0, 2'b11, RA_CMD, 8'h00, OP_SET_FEATURES};
      5'h0E: s = {2'h2, 21'h000000};
      5'h0F: s = {2'h0, 2'b10, RA_DEVHEAD, 16'h0010};
      5'h10: s = {2'h1, 2'b10, RA_CMD, 16'h0000};
      default: s = {2'h3, 21'h000000};
    endcase
    return s;
  endfunction

  // no step touches a control block address  see [RL17]
  assign step = seq_step(pc);
  assign engine_busy = st != HS_IDLE;

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      wreg <= 16'h0000;
    else if (i_wr && i_addr == HR_WDATA)
      wreg <= i_wdata[15:0]; // upper reserved bytes kept zero by software  see [RL3]
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st <= HS_IDLE;
      pc <= 5'h00;
      timer <= 19'h00000;
      bus.cs0_n <= 1'b1;
      bus.cs1_n <= 1'b1;
      bus.da <= 3'h0;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.wdata <= 16'h0000;
    end
    else
    begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      case (st)
        HS_IDLE:
          if (i_wr && i_addr == HR_ACCESS)
          begin
            bus.cs0_n <= !i_wdata[HA_CS0_BIT];
            bus.cs1_n <= !i_wdata[HA_CS1_BIT];
            bus.da <= i_wdata[2:0];
            bus.wdata <= wreg; // see [RL4] see [RL9]
            bus.wr <= !i_wdata[HA_READ_BIT];
            bus.rd <= i_wdata[HA_READ_BIT];
          end
          else if (i_wr && i_addr == HR_SEQ && i_wdata[1:0] != 2'h0)
          begin
            pc <= i_wdata[0] ? SEQ_ENTER_BASE : SEQ_LEAVE_BASE;
            st <= HS_RUN;
          end
        HS_RUN:
          if (step[22:21] == 2'h3)
            st <= HS_IDLE;
          else if (step[22:21] == 2'h2)
          begin
            timer <= 19'(MODE_WAIT_CYCLES - 1); // see [RL15] see [RL16]
            st <= HS_WAIT;
          end
          else
          begin
            bus.cs0_n <= !step[20];
            bus.cs1_n <= !step[19];
            bus.da <= step[18:16];
            bus.wdata <= step[15:0];
            bus.wr <= step[22:21] == 2'h0;
            bus.rd <= step[22:21] == 2'h1;
            pc <= pc + 5'h01;
          end
        HS_WAIT:
          if (timer == 19'h00000)
          begin
            pc <= pc + 5'h01;
            st <= HS_RUN;
          end
          else
            timer <= timer - 19'h00001;
        default:
          st <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      result <= 16'h0000;
    else if (bus.rdata_oe)
      result <= bus.rdata;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 32'h00000000;
    else if (i_rd)
    begin
      if (i_addr == HR_WDATA)
        o_rdata <= {16'h0000, wreg};
      else if (i_addr == HR_RESULT)
        o_rdata <= {15'h0000, engine_busy, result};
      else
        o_rdata <= 32'h00000000;
    end
  end
endmodule

// ### verif/aoq_chk_sva.sv
`timescale 1ns/1ps
module aoq_chk_sva
  import aoq_pkg::*;
(
  input wire logic i_sys_clk, // clock
  input wire logic i_arst_n, // reset
  input wire logic cs0_n, // select 0
  input wire logic cs1_n, // select 1
  input wire logic [2:0] da, // address
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [15:0] wdata, // write data
  input wire logic [15:0] rdata, // read data
  input wire logic rdata_oe, // answer
  input wire logic intrq, // irq dev 0
  input wire logic second_device_interrupt // irq dev 1
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic cmd_sel;
  logic stat_rd;
  logic last_bsy;
  assign cmd_sel = !cs0_n && cs1_n;
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
    if (!i_arst_n)
      stat_rd <= 1'b0;
    else
      stat_rd <= rd && cmd_sel && da == RA_CMD;
  // last busy seen: a write refused while busy must not count as a new command
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
    if (!i_arst_n)
      last_bsy <= 1'b0;
    else if (rdata_oe && stat_rd)
      last_bsy <= rdata[7];
  sequence s_stat_rd;
    rd && cmd_sel && da == RA_CMD ##1 rdata_oe;
  endsequence
  sequence s_plain_cmd;
    wr && cmd_sel && da == RA_CMD && !wdata[15] && wdata[7:0] != OP_SET_FEATURES && !last_bsy;
  endsequence
  chk_oe_after_rd: assert property (rdata_oe |-> $past(rd))
    else $error("answer without read");
  chk_status_rsvd: assert property (s_stat_rd |->
    rdata[14:12] == 3'h0 && rdata[6] && rdata[5:1] == 5'h00)
    else $error("status reserved bits wrong");
  chk_busy_seen: assert property (s_plain_cmd ##[1:8] s_stat_rd |-> rdata[7])
    else $error("busy missing after command");
  chk_upper_zero: assert property (rd && cmd_sel && da inside {[3'h1:3'h5]} ##1
    rdata_oe |-> rdata[15:8] == 8'h00)
    else $error("reserved upper byte not zero");
  chk_devhead_fmt: assert property (rd && cmd_sel && da == RA_DEVHEAD ##1
    rdata_oe |-> rdata[15:5] == 11'h005)
    else $error("device head fixed bits wrong");
  chk_no_irq1: assert property (!second_device_interrupt)
    else $error("device 0 drove second line");
  chk_one_strobe: assert property (!(wr && rd))
    else $error("read and write together");
  chk_alt_keeps: assert property (intrq && rd && cs0_n && !cs1_n && da == RA_DEVCTL |=> intrq)
    else $error("alternate read cleared irq");
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); \
    end \
  end
module tb_top;
  import aoq_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, hwr = 1'b0, hrd = 1'b0;
  logic pd = 1'b0, sreq = 1'b0, sdone = 1'b0, oe;
  logic [1:0] ha = 2'h0;
  logic [31:0] hd = 32'h0, hq, seed = 32'hFFB0;
  logic [3:0] stag = 4'h0, depth, t;
  logic [15:0] q, qv, d;
  int err_total = 0;
  int n_checks = 0;
  aoq_mode_e mode;
  aoq_entry_s ent;
  aoq_bus_if bus ();
  aoq_host #(.MODE_WAIT_CYCLES(20)) u_aoq_host (.i_sys_clk(clk), .i_arst_n(arst_n), .bus(bus),
    .i_addr(ha), .i_wdata(hd), .i_wr(hwr), .i_rd(hrd), .o_rdata(hq));
  aoq_device u_aoq_device (.i_sys_clk(clk), .i_arst_n(arst_n), .bus(bus), .i_dev_id(1'b0),
    .i_power_down(pd), .i_svc_req(sreq), .i_svc_done(sdone), .i_svc_tag(stag),
    .o_id_queue_depth(depth), .o_mode(mode), .o_queue_valid(qv), .o_svc_entry(ent));
  aoq_chk_sva u_aoq_chk_sva (.i_sys_clk(clk), .i_arst_n(arst_n), .cs0_n(bus.cs0_n),
    .cs1_n(bus.cs1_n), .da(bus.da), .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata),
    .rdata(bus.rdata), .rdata_oe(bus.rdata_oe), .intrq(bus.intrq),
    .second_device_interrupt(bus.second_device_interrupt));
  initial
  begin
    forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] dh(input logic [15:0] v);
    return {8'h00, 3'b101, v[4:0]};
  endfunction
  task report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task hw(input logic [1:0] a, input logic [31:0] v);
    @(posedge clk);
    ha <= a;
    hd <= v;
    hwr <= 1'b1;
  endtask
  // c0/c1 high means that select line is asserted
  task acc(input logic c0, c1, input logic [2:0] a, input logic r, input logic [15:0] v);
    hw(HR_WDATA, {16'h0000, v});
    hw(HR_ACCESS, {26'h0, r, c1, c0, a});
    @(posedge clk);
    hwr <= 1'b0;
    oe = 1'b0;
    repeat (3)
    begin
      wt(1);
      if (bus.rdata_oe === 1'b1)
      begin
        oe = 1'b1;
        q = bus.rdata;
      end
    end
  endtask
  task feat(input logic [7:0] code);
    acc(1, 0, RA_FEAT, 0, {8'h00, code});
    acc(1, 0, RA_CMD, 0, {8'h00, OP_SET_FEATURES});
    wt(50);
  endtask
  task qcmd(input logic [3:0] tg);
    acc(1, 0, RA_CMD, 0, {1'b1, 3'h0, tg, 8'h20});
    wt(6);
  endtask
  task svc(input logic req, input logic [3:0] tg);
    @(posedge clk);
    stag <= tg;
    sreq <= req;
    sdone <= !req;
    @(posedge clk);
    sreq <= 1'b0;
    sdone <= 1'b0;
    wt(2);
  endtask
  task seq(input logic [31:0] v);
    hw(HR_SEQ, v);
    @(posedge clk);
    hwr <= 1'b0;
    repeat (300)
    begin
      @(posedge clk);
      ha <= HR_RESULT;
      hrd <= 1'b1;
      @(posedge clk);
      hrd <= 1'b0;
      #1;
      if (hq[HR_BUSY_BIT] === 1'b0)
        break;
    end
    `CHK(hq[HR_BUSY_BIT], 1'b0)
  endtask
  initial
  begin
    #(CLK_PERIOD_NS * 40000);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    wt(2);
    `CHK(mode, legacy_mode)
    `CHK({depth, qv}, {QUEUE_DEPTH_FIELD, 16'h0000})
    acc(1, 0, RA_DEVHEAD, 0, 16'hFF05);
    acc(1, 0, RA_DEVHEAD, 1, 0);
    `CHK(q, dh(16'hFF05))
    for (int i = 2; i < 6; i++)
    begin
      d = 16'(rnd());
      acc(1, 0, i[2:0], 0, d);
      acc(1, 0, i[2:0], 1, 0);
      `CHK(q, {8'h00, d[7:0]})
    end
    acc(1, 0, RA_CMD, 0, {8'h00, 8'h10 | (8'(rnd()) & 8'h0F)});
    acc(1, 0, RA_CMD, 1, 0);
    `CHK(q[7], 1'b1)
    wt(30);
    acc(0, 1, RA_DEVCTL, 1, 0);
    `CHK({q[15], bus.intrq}, 2'b11)
    acc(1, 0, RA_CMD, 1, 0);
    `CHK({q[15], q[7], bus.intrq}, 3'b100)
    feat(8'h55);
    acc(1, 0, RA_CMD, 1, 0);
    `CHK({q[7], q[0], mode}, {2'b01, legacy_mode})
    acc(1, 0, RA_FEAT, 1, 0);
    `CHK(q, {8'h00, ERR_ABORT})
    acc(1, 0, RA_FEAT, 0, {8'h00, FEAT_OVL_BITSEL});
    acc(1, 0, RA_CMD, 0, {8'h00, OP_SET_FEATURES});
    acc(1, 0, RA_CMD, 1, 0);
    `CHK({q[7], mode}, {1'b1, bitselect_overlap_mode})
    wt(50);
    repeat (3)
    begin
      t = 4'(rnd());
      qcmd(t);
      `CHK(qv[t], 1'b1)
    end
    svc(1, t);
    `CHK(ent.cmd, 8'h20)
    acc(0, 1, RA_DEVCTL, 1, 0);
    `CHK({q[15], q[11:8]}, {1'b0, t})
    qcmd(t + 4'h1);
    svc(0, t);
    `CHK({qv[t], qv[t + 4'h1]}, 2'b01)
    acc(0, 1, RA_DEVCTL, 0, 16'h0004);
    acc(0, 1, RA_DEVCTL, 0, 16'h0000);
    `CHK({qv, mode}, {16'h0000, bitselect_overlap_mode})
    qcmd(t);
    @(posedge clk);
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    wt(2);
    `CHK({qv, mode}, {16'h0000, legacy_mode})
    feat(FEAT_OVL_BITSEL);
    qcmd(t);
    feat(FEAT_OVL_OFF);
    `CHK({qv, mode}, {16'h0000, legacy_mode})
    seq(1);
    `CHK(mode, chipselect_overlap_mode)
    // the both-asserted read of the entry sequence must go unanswered by device 0
    `CHK(hq[15:0], q)
    wt(50);
    `CHK(bus.intrq, 1'b1)
    acc(0, 0, RA_DEVCTL, 1, 0);
    `CHK(oe, 1'b1)
    acc(0, 1, RA_DEVCTL, 1, 0);
    `CHK(oe, 1'b0)
    acc(1, 1, RA_CMD, 1, 0);
    `CHK(oe, 1'b0)
    seq(2);
    `CHK(mode, legacy_mode)
    report_and_stop();
  end
endmodule
